// file: rtl/ufbm_pkg.sv
// Purpose: Shared constants and types for the serial format, bank and modem control block
// Assumes: AXI4-Lite register access, 32-bit data, one register per aligned word
// Notes:   Serial timing counts are in ticks of a 16x sample strobe
package ufbm_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_DATA   = 8'h00;
  localparam logic [7:0] ADDR_FIFO   = 8'h04;
  localparam logic [7:0] ADDR_FMT    = 8'h0C;
  localparam logic [7:0] ADDR_MODEM  = 8'h10;
  localparam logic [7:0] ADDR_STAT   = 8'h14;
  localparam logic [7:0] ADDR_SHADOW = 8'h18;
  // Field positions
  localparam int FMT_STOP  = 2;
  localparam int FMT_PAR   = 3;
  localparam int FMT_EVEN  = 4;
  localparam int FMT_STICK = 5;
  localparam int FMT_BRK   = 6;
  localparam int BSR_EN    = 7;
  localparam int MCR_DTR   = 0;
  localparam int MCR_RTS   = 1;
  localparam int MCR_RING  = 2;
  localparam int MCR_LOOP  = 4;
  // Reset values
  localparam logic [7:0] FMT_RST  = 8'h00;
  localparam logic [7:0] BSR_RST  = 8'h00;
  localparam logic [7:0] MCR_RST  = 8'h00;
  localparam logic [7:0] FIFO_RST = 8'h00;
  // Serial timing in sample ticks
  localparam logic [5:0] TICKS_BIT  = 6'h10;
  localparam logic [5:0] TICKS_HALF = 6'h08;
  localparam logic [5:0] TICKS_S15  = 6'h18;
  localparam logic [5:0] TICKS_S2   = 6'h20;
  // FIFO thresholds by code
  localparam logic [4:0] TX_THR [4] = '{5'h01, 5'h03, 5'h09, 5'h0D};
  localparam logic [4:0] RX_THR [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  // Bank select codes for banks 2 to 7
  localparam logic [7:0] BANK_CODE [6] = '{8'hE0, 8'hE4, 8'hE8, 8'hEC, 8'hF0, 8'hF4};
  localparam logic [3:0] BANK_RSVD = 4'hF;
  localparam logic [3:0] BANK_SHADOW = 4'h3;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    UFBM_UART = 3'b000, UFBM_SHARP = 3'b010, UFBM_SIR = 3'b011, UFBM_CIR = 3'b110
  } ufbm_mode_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_START = 3'b001, S_DATA = 3'b010, S_PAR = 3'b011, S_STOP = 3'b100
  } ufbm_ser_t;
endpackage

// file: rtl/ufbm_ctl.sv
// Purpose: Serial format, bank select and modem control with a small serial engine
// Assumes: SAMPLE_TICK is a one-cycle strobe at 16x the bit rate; FIFO levels come from outside
// Notes:   All state freezes while CE is low
module ufbm_ctl
  import ufbm_pkg::*;
(
  input  wire logic                  MCLK,
  input  wire logic                  RESET,
  input  wire logic                  CE,
  input  wire logic [7:0]            AWADDR,
  input  wire logic                  AWVALID,
  output logic                       AWREADY,
  input  wire logic [31:0]           WDATA,
  input  wire logic [3:0]            WSTRB,
  input  wire logic                  WVALID,
  output logic                       WREADY,
  output logic [1:0]                 BRESP,
  output logic                       BVALID,
  input  wire logic                  BREADY,
  input  wire logic [7:0]            ARADDR,
  input  wire logic                  ARVALID,
  output logic                       ARREADY,
  output logic [31:0]                RDATA,
  output logic [1:0]                 RRESP,
  output logic                       RVALID,
  input  wire logic                  RREADY,
  input  wire logic                  EXT_MODE,
  input  ufbm_pkg::ufbm_mode_t       OP_MODE,
  input  wire logic                  SHARP_MOD_EN,
  input  wire logic                  SAMPLE_TICK,
  input  wire logic                  SIN,
  input  wire logic [4:0]            TX_LEVEL,
  input  wire logic [4:0]            RX_LEVEL,
  output logic                       SERIAL_OUT_PIN,
  output logic                       INFRARED_TX_PIN,
  output logic                       DTR_N,
  output logic                       RTS_N,
  output logic                       LOOP_DSR,
  output logic                       LOOP_CTS,
  output logic                       LOOP_RI,
  output logic                       TX_LOW_EVT,
  output logic                       RX_HIGH_EVT,
  output logic [3:0]                 BANK_SEL
);
  import ufbm_pkg::*;

  logic [7:0]  line_format_q, register_bank_select_q, modem_line_control_q, fifo_ctl_q;
  logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q, awready_q, wready_q, arready_q;
  logic [7:0]  aw_addr_q, w_data_q;
  logic        w_strb_q;
  logic [31:0] rdata_q;
  logic [1:0]  bresp_q, rresp_q;
  ufbm_ser_t   tx_st_q, tx_st_d, rx_st_q, rx_st_d;
  logic [5:0]  tx_cnt_q, rx_cnt_q;
  logic [2:0]  tx_idx_q, rx_idx_q;
  logic [7:0]  tx_sh_q, rx_sh_q, rx_data_q;
  logic        tx_line_q, ir_phase_q, rx_avail_q, par_err_q, frm_err_q, rx_par_bad_q;
  logic        serial_out_pin_q, infrared_tx_pin_q, dtr_n_q, rts_n_q, dsr_q, cts_q, ri_q, txlow_q, rxhigh_q;
  logic [3:0]  bank_q;

  // Parity bit over the low n data bits
  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] len,
                                   input logic even, input logic stick);
    logic [7:0] m;
    m = d & (8'hFF >> (3 - len));
    if (stick) begin
      par_bit = ~even;
    end else begin
      par_bit = even ? ^m : ~^m;
    end
  endfunction

  // Bus handshake decode
  wire aw_fire = AWVALID & awready_q;
  wire w_fire  = WVALID & wready_q;
  wire ar_fire = ARVALID & arready_q;
  wire wr_do   = aw_hold_q & w_hold_q & ~bvalid_q;
  wire wr_b0   = wr_do & w_strb_q;
  wire aw_hold_d = (aw_hold_q | aw_fire) & ~wr_do;
  wire w_hold_d  = (w_hold_q | w_fire) & ~wr_do;
  wire bvalid_d  = wr_do | (bvalid_q & ~BREADY);
  wire rvalid_d  = ar_fire | (rvalid_q & ~RREADY);
  wire wr_fmt    = wr_b0 & (aw_addr_q == ADDR_FMT);
  wire wr_fifo   = wr_b0 & (aw_addr_q == ADDR_FIFO);
  wire wr_mcr    = wr_b0 & (aw_addr_q == ADDR_MODEM);
  wire wr_data   = wr_b0 & (aw_addr_q == ADDR_DATA);
  wire wr_hit    = (aw_addr_q == ADDR_FMT) | (aw_addr_q == ADDR_FIFO) | (aw_addr_q == ADDR_MODEM) |
                   (aw_addr_q == ADDR_DATA) | (aw_addr_q == ADDR_STAT) | (aw_addr_q == ADDR_SHADOW);
  wire rd_data   = ar_fire & (ARADDR == ADDR_DATA);
  wire rd_stat   = ar_fire & (ARADDR == ADDR_STAT);

  wire [7:0] fmt_eff = (OP_MODE == UFBM_CIR) ? FMT_RST : line_format_q;
  wire [1:0] len     = fmt_eff[1:0];
  wire       brk     = fmt_eff[FMT_BRK];
  wire       loop    = modem_line_control_q[MCR_LOOP];

  logic [3:0] bank_d;
  always_comb begin
    bank_d = BANK_RSVD;
    if (!register_bank_select_q[7]) begin
      bank_d = 4'h0;
    end else if (!register_bank_select_q[6] || (register_bank_select_q[1:0] != 2'h0)) begin
      bank_d = 4'h1;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (register_bank_select_q == BANK_CODE[i]) begin
          bank_d = 4'(i + 2);
        end
      end
    end
  end

  // Read data selection
  logic [31:0] rd_d;
  logic        rd_ok;
  always_comb begin
    rd_d  = 32'h0000_0000;
    rd_ok = 1'b1;
    case (ARADDR)
      ADDR_DATA:   rd_d[7:0] = rx_data_q;
      ADDR_FIFO:   rd_d[7:0] = fifo_ctl_q;
      ADDR_FMT:    rd_d[7:0] = register_bank_select_q;
      ADDR_MODEM:  rd_d[7:0] = modem_line_control_q;
      ADDR_STAT:   rd_d[5:0] = {rxhigh_q, txlow_q, tx_st_q == S_IDLE, frm_err_q, par_err_q, rx_avail_q};
      // format copy only in bank three
      ADDR_SHADOW: rd_d[7:0] = (bank_q == BANK_SHADOW) ? line_format_q : 8'h00;
      default:     rd_ok = 1'b0;
    endcase
  end

  // Bus channel flops
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      {aw_hold_q, w_hold_q, bvalid_q, rvalid_q} <= 4'h0;
      {awready_q, wready_q, arready_q} <= 3'h7;
      {aw_addr_q, w_data_q, w_strb_q} <= 17'h0_0000;
      {rdata_q, bresp_q, rresp_q} <= 36'h0_0000_0000;
    end else if (CE) begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      awready_q <= ~aw_hold_d;
      wready_q  <= ~w_hold_d;
      bvalid_q  <= bvalid_d;
      rvalid_q  <= rvalid_d;
      arready_q <= ~rvalid_d;
      if (aw_fire) aw_addr_q <= AWADDR;
      if (w_fire) begin
        w_data_q <= WDATA[7:0];
        w_strb_q <= WSTRB[0];
      end
      if (wr_do) bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (ar_fire) begin
        rdata_q <= rd_d;
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Control registers
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      line_format_q          <= FMT_RST;
      register_bank_select_q <= BSR_RST;
      modem_line_control_q   <= MCR_RST;
      fifo_ctl_q             <= FIFO_RST;
    end else if (CE) begin
      if (wr_fmt) begin
        register_bank_select_q <= w_data_q;
        if (!w_data_q[BSR_EN]) line_format_q <= w_data_q;
      end
      if (wr_mcr) modem_line_control_q <= {3'h0, w_data_q[4:0]};
      if (wr_fifo) fifo_ctl_q <= {w_data_q[7:4], 4'h0};
    end
  end

  // Transmit engine next state
  wire [5:0] stop_len  = !fmt_eff[FMT_STOP] ? TICKS_BIT : (len == 2'h0) ? TICKS_S15 : TICKS_S2;
  wire [5:0] tx_len    = (tx_st_q == S_STOP) ? stop_len : TICKS_BIT;
  wire       tx_bitend = SAMPLE_TICK & (tx_cnt_q == tx_len - 6'h01);
  wire [2:0] last_idx  = 3'h4 + {1'b0, len};
  always_comb begin
    tx_st_d = tx_st_q;
    case (tx_st_q)
      S_IDLE:  if (wr_data) tx_st_d = S_START;
      S_START: if (tx_bitend) tx_st_d = S_DATA;
      S_DATA:  if (tx_bitend && tx_idx_q == last_idx) tx_st_d = fmt_eff[FMT_PAR] ? S_PAR : S_STOP;
      S_PAR:   if (tx_bitend) tx_st_d = S_STOP;
      S_STOP:  if (tx_bitend) tx_st_d = S_IDLE;
      default: tx_st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      tx_st_q <= S_IDLE;
      {tx_cnt_q, tx_idx_q, tx_sh_q} <= 17'h0_0000;
      tx_line_q  <= 1'b1;
      ir_phase_q <= 1'b0;
    end else if (CE) begin
      tx_st_q <= tx_st_d;
      if (SAMPLE_TICK) ir_phase_q <= ~ir_phase_q;
      if (tx_st_q == S_IDLE) begin
        tx_cnt_q <= 6'h00;
        tx_idx_q <= 3'h0;
        if (wr_data) tx_sh_q <= w_data_q;
      end else if (SAMPLE_TICK) begin
        tx_cnt_q <= tx_bitend ? 6'h00 : tx_cnt_q + 6'h01;
        if (tx_bitend && tx_st_q == S_DATA) tx_idx_q <= tx_idx_q + 3'h1;
      end
      case (tx_st_d)
        S_START: tx_line_q <= 1'b0;
        S_DATA:  tx_line_q <= tx_sh_q[tx_st_q == S_DATA ? tx_idx_q + 3'(tx_bitend) : 3'h0];
        S_PAR:   tx_line_q <= par_bit(tx_sh_q, len, fmt_eff[FMT_EVEN], fmt_eff[FMT_STICK]);
        default: tx_line_q <= 1'b1;
      endcase
    end
  end

  // Receive engine next state
  wire rx_in     = loop ? tx_line_q : SIN;
  wire rx_sample = SAMPLE_TICK & (rx_cnt_q == TICKS_BIT - 6'h01);
  wire rx_mid    = SAMPLE_TICK & (rx_cnt_q == TICKS_HALF - 6'h01);
  wire [7:0] rx_char = rx_sh_q >> (3 - len);
  always_comb begin
    rx_st_d = rx_st_q;
    case (rx_st_q)
      S_IDLE:  if (SAMPLE_TICK && !rx_in) rx_st_d = S_START;
      S_START: if (rx_mid) rx_st_d = rx_in ? S_IDLE : S_DATA;
      S_DATA:  if (rx_sample && rx_idx_q == last_idx) rx_st_d = fmt_eff[FMT_PAR] ? S_PAR : S_STOP;
      S_PAR:   if (rx_sample) rx_st_d = S_STOP;
      S_STOP:  if (rx_sample) rx_st_d = S_IDLE;
      default: rx_st_d = S_IDLE;
    endcase
  end

  // Receive counters, shifter and flags; set wins over read clear
  wire rx_done = (rx_st_q == S_STOP) & rx_sample;
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      rx_st_q <= S_IDLE;
      {rx_cnt_q, rx_idx_q, rx_sh_q, rx_data_q} <= 25'h000_0000;
      {rx_avail_q, par_err_q, frm_err_q, rx_par_bad_q} <= 4'h0;
    end else if (CE) begin
      rx_st_q <= rx_st_d;
      if (rx_st_q == S_IDLE || (rx_st_q == S_START && rx_mid)) begin
        rx_cnt_q <= 6'h00;
        rx_idx_q <= 3'h0;
      end else if (SAMPLE_TICK) begin
        rx_cnt_q <= rx_sample ? 6'h00 : rx_cnt_q + 6'h01;
      end
      if (rx_sample && rx_st_q == S_DATA) begin
        rx_sh_q  <= {rx_in, rx_sh_q[7:1]};
        rx_idx_q <= rx_idx_q + 3'h1;
      end
      if (rx_sample && rx_st_q == S_PAR)
        rx_par_bad_q <= rx_in != par_bit(rx_char, len, fmt_eff[FMT_EVEN], fmt_eff[FMT_STICK]);
      else if (rx_st_q == S_START) rx_par_bad_q <= 1'b0;
      if (rx_done) rx_data_q <= rx_char;
      rx_avail_q <= rx_done | (rx_avail_q & ~rd_data);
      par_err_q  <= (rx_done & rx_par_bad_q) | (par_err_q & ~rd_stat);
      frm_err_q  <= (rx_done & ~rx_in) | (frm_err_q & ~rd_stat);
    end
  end

  // Output stage values
  wire is_uart  = OP_MODE == UFBM_UART;
  wire ir_pulse = (OP_MODE == UFBM_SIR) | (OP_MODE == UFBM_SHARP && SHARP_MOD_EN);
  wire serial_out_pin_d   = is_uart ? (brk ? 1'b0 : (loop | tx_line_q)) : 1'b1;
  wire ir_brk   = ir_pulse ? ir_phase_q : 1'b1;
  wire ir_norm  = ir_pulse ? (~tx_line_q & ir_phase_q) : ~tx_line_q;
  wire infrared_tx_pin_d   = (OP_MODE == UFBM_SIR || OP_MODE == UFBM_SHARP) & ~loop & (brk ? ir_brk : ir_norm);
  wire txlow_d  = EXT_MODE ? (TX_LEVEL < TX_THR[fifo_ctl_q[5:4]]) : (TX_LEVEL == 5'h00);
  wire rxhigh_d = RX_LEVEL >= RX_THR[fifo_ctl_q[7:6]];

  // Registered pins
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      {serial_out_pin_q, dtr_n_q, rts_n_q} <= 3'h7;
      {infrared_tx_pin_q, dsr_q, cts_q, ri_q, txlow_q, rxhigh_q} <= 6'h00;
      bank_q <= 4'h0;
    end else if (CE) begin
      serial_out_pin_q   <= serial_out_pin_d;
      infrared_tx_pin_q   <= infrared_tx_pin_d;
      dtr_n_q  <= ~(modem_line_control_q[MCR_DTR] & ~loop);
      rts_n_q  <= ~(modem_line_control_q[MCR_RTS] & ~loop);
      dsr_q    <= loop & modem_line_control_q[MCR_DTR];
      cts_q    <= loop & modem_line_control_q[MCR_RTS];
      ri_q     <= loop & (EXT_MODE ? modem_line_control_q[MCR_DTR] : modem_line_control_q[MCR_RING]);
      txlow_q  <= txlow_d;
      rxhigh_q <= rxhigh_d;
      bank_q   <= bank_d;
    end
  end

  assign {AWREADY, WREADY, ARREADY} = {awready_q, wready_q, arready_q};
  assign {BVALID, BRESP, RVALID, RDATA, RRESP} = {bvalid_q, bresp_q, rvalid_q, rdata_q, rresp_q};
  assign {SERIAL_OUT_PIN, INFRARED_TX_PIN, DTR_N, RTS_N} = {serial_out_pin_q, infrared_tx_pin_q, dtr_n_q, rts_n_q};
  assign {LOOP_DSR, LOOP_CTS, LOOP_RI} = {dsr_q, cts_q, ri_q};
  assign {TX_LOW_EVT, RX_HIGH_EVT, BANK_SEL} = {txlow_q, rxhigh_q, bank_q};

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence loop_dtr_s;
    CE && loop && modem_line_control_q[MCR_DTR];
  endsequence
  sequence loop_seen_s;
    LOOP_DSR && DTR_N;
  endsequence

  tx_thr_a: assert property (CE && EXT_MODE && TX_LEVEL >= TX_THR[fifo_ctl_q[5:4]] |=> !TX_LOW_EVT)
    else $error("tx event at or above threshold");
  tx_ignore_a: assert property (CE && !EXT_MODE && TX_LEVEL != 5'h00 |=> !TX_LOW_EVT)
    else $error("tx threshold used in non-extended mode");
  rx_thr_a: assert property (CE && RX_LEVEL >= RX_THR[fifo_ctl_q[7:6]] |=> RX_HIGH_EVT)
    else $error("rx event missing at threshold");
  fmt_read_a: assert property (CE && ar_fire && ARADDR == ADDR_FMT |=> RDATA[7:0] == $past(register_bank_select_q))
    else $error("shared address did not return bank select");
  fmt_write_a: assert property (CE && wr_fmt && !w_data_q[BSR_EN] |=> line_format_q == $past(w_data_q))
    else $error("format not written with top bit clear");
  fmt_keep_a: assert property (CE && wr_fmt && w_data_q[BSR_EN] |=> $stable(line_format_q))
    else $error("format changed with top bit set");
  break_low_a: assert property (CE && brk && is_uart |=> !SERIAL_OUT_PIN)
    else $error("break did not force serial output low");
  loop_route_a: assert property (loop_dtr_s |=> loop_seen_s)
    else $error("loopback did not route terminal ready");
  dtr_drive_a: assert property (CE && !loop && modem_line_control_q[MCR_DTR] |=> !DTR_N)
    else $error("terminal ready not driven low");

endmodule // ufbm_ctl

// file: test/ufbm_peer.sv
// Purpose: Serial peer that frames characters onto the line and captures the block output
// Assumes: One bit lasts 16 sample ticks; the line idles high
// Notes:   Tasks are called from the bench
module ufbm_peer (
  input  wire logic clk,
  input  wire logic tick,
  input  wire logic ser_in,
  output logic      ser_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ser_out = 1'h1;
  // Send n bits in line order, start bit first
  task automatic send(input logic [11:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      ser_out <= v[i];
      repeat (16) @(posedge clk iff tick);
    end
    ser_out <= 1'h1;
  endtask
  // Wait for a start edge, then sample each bit in its middle
  task automatic cap(output logic [11:0] v, output bit ok);
    int n;
    n = 0;
    while (ser_in !== 1'h0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    ok = (n < 4000);
    repeat (8) @(posedge clk iff tick);
    for (int i = 0; i < 12; i++) begin
      v[i] = ser_in;
      repeat (16) @(posedge clk iff tick);
    end
  endtask
endmodule // ufbm_peer

// file: test/tb_uart_format_bank_modem_ctl.sv
// Purpose: Self-checking bench for the format, bank and modem control block
// Assumes: AXI4-Lite master tasks; sample tick every second clock
// Notes:   Row table first, then hand-written awkward cases
module tb_uart_format_bank_modem_ctl import ufbm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic       e;
    logic [7:0] f;
    logic [4:0] t;
    logic [4:0] x;
    logic [7:0] b;
    logic       et;
    logic       ex;
    logic [3:0] k;
  } ufbm_row_t;
  logic        mclk, reset, ce, awvalid, wvalid, bready, arvalid, rready, ext, smod, tick, sin;
  logic        awready, wready, bvalid, arready, rvalid, serial_out_pin, infrared_tx_pin, dtr_n, rts_n, ldsr, lcts, lri, txe, rxe;
  logic [7:0]  awaddr, araddr, s;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, bank;
  logic [4:0]  txl, rxl;
  logic [1:0]  bresp, rresp, rsp;
  logic [11:0] fv;
  bit          fok;
  ufbm_mode_t  mode;
  int          err_total, compares, hi;
  ufbm_row_t   rows [12] = '{
    '{1'h1, 8'h00, 5'h00, 5'h01, 8'h00, 1'h1, 1'h1, 4'h0}, '{1'h1, 8'h50, 5'h02, 5'h03, 8'h80, 1'h1, 1'h0, 4'h1},
    '{1'h1, 8'hA0, 5'h09, 5'h08, 8'hC1, 1'h0, 1'h1, 4'h1}, '{1'h1, 8'hF0, 5'h0C, 5'h0D, 8'hE0, 1'h1, 1'h0, 4'h2},
    '{1'h0, 8'hF0, 5'h05, 5'h0E, 8'hE4, 1'h0, 1'h1, 4'h3}, '{1'h0, 8'hF0, 5'h00, 5'h00, 8'hE8, 1'h1, 1'h0, 4'h4},
    '{1'h1, 8'h00, 5'h01, 5'h00, 8'hEC, 1'h0, 1'h0, 4'h5}, '{1'h1, 8'hA0, 5'h08, 5'h07, 8'hF0, 1'h1, 1'h0, 4'h6},
    '{1'h1, 8'h50, 5'h03, 5'h04, 8'hF4, 1'h0, 1'h1, 4'h7}, '{1'h1, 8'h50, 5'h03, 5'h04, 8'hF8, 1'h0, 1'h1, 4'hF},
    '{1'h1, 8'h50, 5'h03, 5'h04, 8'hC4, 1'h0, 1'h1, 4'hF}, '{1'h1, 8'h50, 5'h03, 5'h04, 8'h7E, 1'h0, 1'h1, 4'h0}};
  logic [7:0]  fm [6] = '{8'h00, 8'h0B, 8'h1A, 8'h29, 8'h3B, 8'h07};
  ufbm_mode_t  md [4] = '{UFBM_SIR, UFBM_SHARP, UFBM_SHARP, UFBM_CIR};
  logic [7:0]  mw [3] = '{8'h07, 8'h17, 8'hF4};
  logic [4:0]  me [3] = '{5'h00, 5'h1F, 5'h19};

  ufbm_ctl i_dut (.MCLK(mclk), .RESET(reset), .CE(ce), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .EXT_MODE(ext), .OP_MODE(mode), .SHARP_MOD_EN(smod),
    .SAMPLE_TICK(tick), .SIN(sin), .TX_LEVEL(txl), .RX_LEVEL(rxl), .SERIAL_OUT_PIN(serial_out_pin), .INFRARED_TX_PIN(infrared_tx_pin), .DTR_N(dtr_n),
    .RTS_N(rts_n), .LOOP_DSR(ldsr), .LOOP_CTS(lcts), .LOOP_RI(lri), .TX_LOW_EVT(txe), .RX_HIGH_EVT(rxe),
    .BANK_SEL(bank));
  ufbm_peer i_peer (.clk(mclk), .tick(tick), .ser_in(serial_out_pin), .ser_out(sin));

  // Clock and a one-cycle sample strobe every second cycle
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) tick <= reset ? 1'h0 : ~tick;

  task automatic tally_and_finish();
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 400) begin
      chk("wait bound", 0, 1);
      tally_and_finish();
    end
  endtask
  // Bus write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int   n;
    logic aw, w;
    n = 0;
    aw = 1'h1;
    w = 1'h1;
    @(posedge mclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'h7};
    while ((aw || w) && n < 400) begin
      @(posedge mclk);
      n++;
      if (aw && awready) begin
        aw = 1'h0;
        awvalid <= 1'h0;
      end
      if (w && wready) begin
        w = 1'h0;
        wvalid <= 1'h0;
      end
    end
    while (!bvalid && n < 400) begin
      @(posedge mclk);
      n++;
    end
    r = bresp;
    bready <= 1'h0;
    guard(n);
  endtask
  // Bus read: request held until taken, ready held until data seen
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do begin @(posedge mclk); n++; end while (!arready && n < 400);
    arvalid <= 1'h0;
    do begin @(posedge mclk); n++; end while (!rvalid && n < 400);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'h0;
    guard(n);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d);
  endtask
  // Poll status until the transmitter is idle
  task automatic idle_wait();
    int n;
    n = 0;
    do begin rd(ADDR_STAT, s, rsp); n++; end while (s[3] !== 1'h1 && n < 400);
    guard(n);
  endtask
  // Expected line bits: start, data, optional parity, idle high after
  function automatic logic [11:0] frm(input logic [7:0] f, input logic [7:0] d);
    logic [11:0] v;
    logic [7:0]  m;
    int          nb;
    nb = 5 + f[1:0];
    m = 8'hFF >> (8 - nb);
    v = 12'hFFE;
    for (int i = 0; i < nb; i++) v[i + 1] = d[i];
    if (f[3]) v[nb + 1] = f[5] ? ~f[4] : (f[4] ? ^(d & m) : ~^(d & m));
    return v;
  endfunction

  // Main sequence
  initial begin
    reset = 1'h1;
    ce = 1'h1;
    wstrb = 4'hF;
    mode = UFBM_UART;
    {txl, rxl, awaddr, araddr, wdata} = 58'h0;
    {awvalid, wvalid, bready, arvalid, rready, ext, smod} = 7'h00;
    err_total = 0;
    compares = 0;
    repeat (8) @(posedge mclk);
    reset <= 1'h0;
    rc("fmt at reset", ADDR_FMT, 8'h00);
    for (int i = 0; i < 12; i++) begin
      @(posedge mclk);
      {ext, txl, rxl} <= {rows[i].e, rows[i].t, rows[i].x};
      wr(ADDR_FIFO, rows[i].f, rsp);
      wr(ADDR_FMT, rows[i].b, rsp);
      rc("bank reg", ADDR_FMT, rows[i].b);
      chk("bank sel", rows[i].k, bank);
      chk("tx event", rows[i].et, txe);
      chk("rx event", rows[i].ex, rxe);
    end
    wr(ADDR_FMT, 8'h03, rsp);
    wr(ADDR_FMT, 8'hF4, rsp);
    wr(ADDR_FMT, 8'hE4, rsp);
    rc("shadow", ADDR_SHADOW, 8'h03);
    foreach (fm[i]) begin
      wr(ADDR_FMT, fm[i], rsp);
      fork
        i_peer.cap(fv, fok);
        wr(ADDR_DATA, 8'hB6, rsp);
      join
      chk("tx frame", frm(fm[i], 8'hB6), fv);
      chk("tx start", 1, fok);
      if (!fok) tally_and_finish();
      idle_wait();
    end
    wr(ADDR_FMT, 8'h1F, rsp);
    for (int i = 0; i < 3; i++) begin
      i_peer.send(frm(8'h1F, 8'h5A) ^ (12'h100 << i) & 12'h600, 11);
      rd(ADDR_STAT, s, rsp);
      chk("rx status", (i == 0) ? 3'h1 : (i == 1) ? 3'h3 : 3'h5, s[2:0]);
      rc("rx data", ADDR_DATA, 8'h5A);
    end
    wr(ADDR_FMT, 8'h43, rsp);
    @(negedge mclk);
    chk("break out", 0, serial_out_pin);
    wr(ADDR_DATA, 8'h55, rsp);
    repeat (200) @(posedge mclk);
    chk("break hold", 0, serial_out_pin);
    idle_wait();
    for (int i = 0; i < 4; i++) begin
      mode <= md[i];
      smod <= (i == 1);
      repeat (4) @(posedge mclk);
      hi = 0;
      repeat (64) begin @(posedge mclk); hi += (infrared_tx_pin === 1'h1); end
      chk("ir out", (i < 2) ? 1 : (i == 2) ? 2 : 0, (hi == 0) ? 0 : (hi == 64) ? 2 : 1);
    end
    chk("cir out", 1, serial_out_pin);
    mode <= UFBM_UART;
    wr(ADDR_FMT, 8'h03, rsp);
    @(negedge mclk);
    chk("break off", 1, serial_out_pin);
    ext <= 1'h0;
    foreach (mw[i]) begin
      wr(ADDR_MODEM, mw[i], rsp);
      rc("modem reg", ADDR_MODEM, mw[i] & 8'h1F);
      chk("modem pins", me[i], {dtr_n, rts_n, ldsr, lcts, lri});
    end
    wr(ADDR_DATA, 8'h3C, rsp);
    idle_wait();
    chk("loop out", 1, serial_out_pin);
    rc("loop data", ADDR_DATA, 8'h3C);
    wr(8'h1C, 8'h00, rsp);
    chk("wr resp", RESP_SLVERR, rsp);
    rd(8'h1C, s, rsp);
    chk("rd resp", RESP_SLVERR, rsp);
    wstrb <= 4'h0;
    wr(ADDR_MODEM, 8'h03, rsp);
    wstrb <= 4'hF;
    rc("strobe off", ADDR_MODEM, 8'h14);
    reset <= 1'h1;
    repeat (3) @(posedge mclk);
    reset <= 1'h0;
    chk("bank reset", 0, bank);
    wr(ADDR_FMT, 8'hE4, rsp);
    rc("shadow reset", ADDR_SHADOW, 8'h00);
    tally_and_finish();
  end
endmodule // tb_uart_format_bank_modem_ctl
